// *** shared/pms_regs.svh ***
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
// base tick 1 ms; measurement cycle in active mode is 1000 ticks, about once per second
`define PMS_TICK_US 1000
`define PMS_CLK_MHZ 100
`define PMS_TICK_CYCLES (`PMS_TICK_US * `PMS_CLK_MHZ)
`define PMS_ACTIVE_TICKS 1000
`define PMS_STANDBY_TICKS 8000
`define PMS_SHIP_TICKS 16000
`define PMS_IDLE_TICKS 30000
`define PMS_FAULT_DELAY_RESET 16'h000a
`define PMS_SWITCH_CHECK_TICKS 16'h0032
`define PMS_LOG_DEPTH 10
`define PMS_NUM_FAULTS 6
`define PMS_NUM_SAFETY 5
`define PMS_NUM_EXT 3
`define PMS_EXT_POL_RESET 3'h0
`endif

// *** shared/pms_pkg.sv ***
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_ACTIVE,
    PMS_STANDBY,
    PMS_SHIP,
    PMS_DEEP_UV
  } pms_mode_type;

  typedef struct packed {
    logic chg;
    logic dsg;
    logic pre;
  } pms_switch_type;

  // first-level faults: cell uv, cell ov, cell ut, cell ot, sys ov, sys oc
  typedef struct packed {
    logic sys_oc;
    logic sys_ov;
    logic cell_ot;
    logic cell_ut;
    logic cell_ov;
    logic cell_uv;
  } pms_fault_type;

  // second-level: safety ov, safety ot, safety oc, measure fail, switch fail (internal)
  typedef struct packed {
    logic meas_fail;
    logic safe_oc;
    logic safe_ot;
    logic safe_ov;
  } pms_safety_type;

  typedef struct packed {
    logic [5:0] code;
    logic [15:0] stamp;
  } pms_log_entry_type;
endpackage

// *** core/pms_persist.sv ***
`include "pms_regs.svh"
// holds a condition until it has persisted for one tick more than its programmed number of ticks
module pms_persist
  import pms_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_sync_n,
  input wire logic tick,
  input wire logic cond,
  input wire logic [CNT_W-1:0] delay,
  output logic qualified
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic hit;
  } pms_persist_state_type;

  pms_persist_state_type state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (!cond) begin
      state_next.cnt = '0;
      state_next.hit = 1'b0;
    end else if (tick && !state_reg.hit) begin
      if (state_reg.cnt >= delay) begin
        state_next.hit = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign qualified = state_reg.hit;
endmodule

// *** core/pms_power_safety.sv ***
`include "pms_regs.svh"
module pms_power_safety
  import pms_pkg::*;
#(
  parameter int TICK_CYCLES = `PMS_TICK_CYCLES,
  parameter int ACTIVE_TICKS = `PMS_ACTIVE_TICKS,
  parameter int STANDBY_TICKS = `PMS_STANDBY_TICKS,
  parameter int SHIP_TICKS = `PMS_SHIP_TICKS,
  parameter int IDLE_TICKS = `PMS_IDLE_TICKS,
  parameter int NUM_EXT = `PMS_NUM_EXT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pms_fault_type fault_raw,
  input wire pms_safety_type safety_raw,
  input wire logic [15:0] fault_delay [`PMS_NUM_FAULTS],
  input wire logic [15:0] safety_delay [`PMS_NUM_SAFETY],
  input wire logic [15:0] switch_check_delay,
  input wire logic fault_clear,
  input wire logic load_active,
  input wire logic cell_below_deep_uv,
  input wire logic cell_above_recovery,
  input wire logic charger_present,
  input wire logic ship_cmd,
  input wire logic host_bus_activity,
  input wire logic [NUM_EXT-1:0] ext_switch_in,
  input wire logic [NUM_EXT-1:0] ext_polarity,
  input wire pms_switch_type switch_sense,
  input wire logic [3:0] log_rd_index,
  output pms_switch_type switch_drive,
  output logic fuse_trip_output,
  output logic meas_start,
  output logic flash_store,
  output logic safety_enable,
  output pms_mode_type mode,
  output pms_log_entry_type log_rd_data,
  output logic [3:0] log_count
);
  localparam int LOG_DEPTH = `PMS_LOG_DEPTH;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] bus_s;
    logic [1:0] ld_s;
    logic [1:0] duv_s;
    logic [1:0] rec_s;
    logic [1:0] chgp_s;
    logic [31:0] div_cnt;
    logic [31:0] meas_cnt;
    logic [31:0] idle_cnt;
    pms_mode_type mode;
    pms_switch_type drive;
    logic fault_latched;
    logic fuse;
    logic meas;
    logic flash;
    pms_fault_type seen;
    logic [3:0] wr_ptr;
    logic [3:0] count;
    logic [15:0] stamp;
  } pms_state_type;

  pms_state_type state_reg, state_next;
  pms_log_entry_type log_reg [LOG_DEPTH];
  pms_log_entry_type log_wr_data;
  logic log_wr;

  // the synchronised reset is the only reset the rest of the block sees
  logic [1:0] rst_pipe_reg;
  logic rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  // pins from the pack side pass two flops; only stage [1] is read
  logic [NUM_EXT-1:0] ext_m_reg, ext_s_reg;
  logic bus_m_reg, bus_s_reg, ld_m_reg, ld_s_reg;
  logic duv_m_reg, duv_s_reg, rec_m_reg, rec_s_reg, cp_m_reg, cp_s_reg;
  pms_switch_type sense_m_reg, sense_s_reg;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_m_reg <= '0;
      ext_s_reg <= '0;
      {bus_m_reg, bus_s_reg, ld_m_reg, ld_s_reg} <= 4'h0;
      {duv_m_reg, duv_s_reg, rec_m_reg, rec_s_reg, cp_m_reg, cp_s_reg} <= 6'h00;
      sense_m_reg <= '0;
      sense_s_reg <= '0;
    end else begin
      ext_m_reg <= ext_switch_in;
      ext_s_reg <= ext_m_reg;
      {bus_m_reg, ld_m_reg, duv_m_reg} <= {host_bus_activity, load_active, cell_below_deep_uv};
      {bus_s_reg, ld_s_reg, duv_s_reg} <= {bus_m_reg, ld_m_reg, duv_m_reg};
      {rec_m_reg, cp_m_reg} <= {cell_above_recovery, charger_present};
      {rec_s_reg, cp_s_reg} <= {rec_m_reg, cp_m_reg};
      sense_m_reg <= switch_sense;
      sense_s_reg <= sense_m_reg;
    end
  end

  logic tick;
  assign tick = (state_reg.div_cnt == 32'(TICK_CYCLES - 1));

  // external switch request: asserted when pin equals its active polarity
  logic ext_open;
  assign ext_open = |(~(ext_s_reg ^ ext_polarity));

  // first-level qualifiers, one per fault
  logic [`PMS_NUM_FAULTS-1:0] fault_q;
  logic [`PMS_NUM_SAFETY-1:0] safety_q;
  logic [`PMS_NUM_SAFETY-1:0] safety_cond;
  logic stuck_closed;
  // a switch reported closed while commanded open
  assign stuck_closed = |(sense_s_reg & ~state_reg.drive);
  assign safety_cond = {stuck_closed, safety_raw};

  genvar gi;
  generate
    for (gi = 0; gi < `PMS_NUM_FAULTS; gi++) begin : g_fault
      pms_persist u_persist (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .tick(tick),
        .cond(fault_raw[gi] && safety_enable),
        .delay(fault_delay[gi]),
        .qualified(fault_q[gi])
      );
    end
    // second-level checks run from raw inputs, not from first-level state
    for (gi = 0; gi < `PMS_NUM_SAFETY; gi++) begin : g_safety
      pms_persist u_persist (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .tick(tick),
        .cond(safety_cond[gi] && safety_enable),
        .delay((gi == `PMS_NUM_SAFETY - 1) ? switch_check_delay : safety_delay[gi]),
        .qualified(safety_q[gi])
      );
    end
  endgenerate

  logic any_fault;
  assign any_fault = |fault_q;

  always_comb begin
    state_next = state_reg;
    log_wr = 1'b0;
    log_wr_data = '0;
    state_next.meas = 1'b0;
    state_next.flash = 1'b0;
    state_next.div_cnt = tick ? 32'h0 : state_reg.div_cnt + 32'h1;
    if (tick) begin
      state_next.stamp = state_reg.stamp + 16'h1;
      state_next.meas_cnt = state_reg.meas_cnt + 32'h1;
      state_next.idle_cnt = ld_s_reg ? 32'h0 : state_reg.idle_cnt + 32'h1;
    end
    unique case (state_reg.mode)
      PMS_ACTIVE: begin
        if (tick && state_reg.meas_cnt >= 32'(ACTIVE_TICKS - 1)) begin
          state_next.meas = 1'b1;
          state_next.meas_cnt = 32'h0;
        end
        if (ship_cmd) begin
          state_next.mode = PMS_SHIP;
        end else if (!ld_s_reg && state_reg.idle_cnt >= 32'(IDLE_TICKS)) begin
          state_next.mode = PMS_STANDBY;
          state_next.meas_cnt = 32'h0;
        end
      end
      PMS_STANDBY: begin
        if (tick && state_reg.meas_cnt >= 32'(STANDBY_TICKS - 1)) begin
          state_next.meas = 1'b1;
          state_next.meas_cnt = 32'h0;
        end
        if (ship_cmd) begin
          state_next.mode = PMS_SHIP;
        end else if (ld_s_reg) begin
          state_next.mode = PMS_ACTIVE;
          state_next.idle_cnt = 32'h0;
        end
      end
      PMS_SHIP: begin
        if (tick && state_reg.meas_cnt >= 32'(SHIP_TICKS - 1)) begin
          state_next.meas = 1'b1;
          state_next.flash = 1'b1;
          state_next.meas_cnt = 32'h0;
        end
        if (bus_s_reg) begin
          state_next.mode = PMS_ACTIVE;
          state_next.idle_cnt = 32'h0;
        end
      end
      PMS_DEEP_UV: begin
        if (rec_s_reg && !duv_s_reg) begin
          state_next.mode = PMS_ACTIVE;
          state_next.idle_cnt = 32'h0;
        end
      end
      default: state_next.mode = PMS_ACTIVE;
    endcase
    // deep undervoltage pre-empts every other mode
    if (duv_s_reg) begin
      state_next.mode = PMS_DEEP_UV;
    end

    // first-level: latch open until software clears and the fault is gone
    if (any_fault) begin
      state_next.fault_latched = 1'b1;
    end else if (fault_clear) begin
      state_next.fault_latched = 1'b0;
    end
    // log each newly qualified fault once
    state_next.seen = pms_fault_type'(fault_q);
    if (|(fault_q & ~state_reg.seen)) begin
      log_wr = 1'b1;
      log_wr_data.code = fault_q & ~state_reg.seen;
      log_wr_data.stamp = state_reg.stamp;
      state_next.wr_ptr = (state_reg.wr_ptr == 4'(LOG_DEPTH - 1)) ? 4'h0 : state_reg.wr_ptr + 4'h1;
      if (state_reg.count != 4'(LOG_DEPTH)) begin
        state_next.count = state_reg.count + 4'h1;
      end
    end

    // switch drive per mode
    unique case (state_next.mode)
      PMS_SHIP: state_next.drive = '0;
      PMS_DEEP_UV: state_next.drive = '{chg: 1'b0, dsg: 1'b0, pre: cp_s_reg};
      default: begin
        if (state_next.fault_latched || any_fault || ext_open) begin
          state_next.drive = '0;
        end else begin
          state_next.drive = '{chg: 1'b1, dsg: 1'b1, pre: 1'b1};
        end
      end
    endcase

    // fuse is permanent once any second-level check qualifies
    if (|safety_q) begin
      state_next.fuse = 1'b1;
    end
    if (state_next.fuse) begin
      state_next.drive = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // log storage kept outside the state struct so it stays an indexed array
  genvar li;
  generate
    for (li = 0; li < LOG_DEPTH; li++) begin : g_log
      always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          log_reg[li] <= '0;
        end else if (log_wr && state_reg.wr_ptr == 4'(li)) begin
          log_reg[li] <= log_wr_data;
        end
      end
    end
  endgenerate

  // safety off in ship and deep-undervoltage
  assign safety_enable = (state_reg.mode == PMS_ACTIVE) || (state_reg.mode == PMS_STANDBY);
  assign switch_drive = state_reg.drive;
  assign fuse_trip_output = state_reg.fuse;
  assign meas_start = state_reg.meas;
  assign flash_store = state_reg.flash;
  assign mode = state_reg.mode;
  assign log_count = state_reg.count;
  // index beyond the log reads zero
  assign log_rd_data = (log_rd_index < 4'(LOG_DEPTH)) ? log_reg[log_rd_index] : '0;
endmodule

// *** test/pms_power_safety_asserts.sv ***
module pms_power_safety_asserts
  import pms_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cell_below_deep_uv,
  input wire logic ship_cmd,
  input wire pms_switch_type switch_drive,
  input wire logic fuse_trip_output,
  input wire logic meas_start,
  input wire logic flash_store,
  input wire logic safety_enable,
  input wire pms_mode_type mode,
  input wire logic [3:0] log_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // two samples so a registered output may trail the mode by one edge
  sequence s_ship2;
    (mode == PMS_SHIP)[*2];
  endsequence
  sequence s_deep2;
    (mode == PMS_DEEP_UV)[*2];
  endsequence
  property p_fuse_sticky; fuse_trip_output |=> fuse_trip_output; endproperty
  a_fuse_sticky: assert property (p_fuse_sticky) else $error("fuse released");
  property p_fuse_opens; fuse_trip_output |-> switch_drive == 3'h0; endproperty
  a_fuse_opens: assert property (p_fuse_opens) else $error("switch closed while fuse tripped");
  property p_ship_open; s_ship2 |-> switch_drive == 3'h0 && !safety_enable; endproperty
  a_ship_open: assert property (p_ship_open) else $error("ship mode left switches or safety on");
  property p_deep_open; s_deep2 |-> !switch_drive.chg && !switch_drive.dsg && !safety_enable; endproperty
  a_deep_open: assert property (p_deep_open) else $error("deep shutdown left switches on");
  property p_ship_cmd;
    $rose(mode == PMS_SHIP) |-> $past(ship_cmd) || $past(ship_cmd, 2) || $past(ship_cmd, 3);
  endproperty
  a_ship_cmd: assert property (p_ship_cmd) else $error("ship entered without command");
  property p_flash; flash_store |-> meas_start && mode == PMS_SHIP; endproperty
  a_flash: assert property (p_flash) else $error("flash store outside ship sample");
  property p_log_max; log_count <= 4'ha; endproperty
  a_log_max: assert property (p_log_max) else $error("log count above depth");
  property p_meas_pulse; meas_start |=> !meas_start; endproperty
  a_meas_pulse: assert property (p_meas_pulse) else $error("measure pulse too long");
  property p_deep_enter; cell_below_deep_uv [*4] |=> mode == PMS_DEEP_UV; endproperty
  a_deep_enter: assert property (p_deep_enter) else $error("deep shutdown not entered");
endmodule

bind pms_power_safety pms_power_safety_asserts u_pms_power_safety_asserts (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .cell_below_deep_uv(cell_below_deep_uv),
  .ship_cmd(ship_cmd),
  .switch_drive(switch_drive),
  .fuse_trip_output(fuse_trip_output),
  .meas_start(meas_start),
  .flash_store(flash_store),
  .safety_enable(safety_enable),
  .mode(mode),
  .log_count(log_count)
);

// *** test/pms_switch_model.sv ***
// switches follow the drive one cycle late; stuck_closed welds the charge switch
module pms_switch_model
  import pms_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pms_switch_type switch_drive,
  input wire logic stuck_closed,
  output pms_switch_type switch_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_sense <= '0;
    end else begin
      switch_sense <= switch_drive | {stuck_closed, 2'b00};
    end
  end
endmodule

// *** test/pms_power_safety_tb_top.sv ***
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
`define WT(c) repeat (300) if (!(c)) @(posedge core_clk);
module pms_power_safety_tb_top;
  import pms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, fault_clear = 0, load_active = 1, below = 0, above = 0;
  logic charger = 0, ship_cmd = 0, host_act = 0, stuck = 0;
  logic [2:0] ext_in = 3'h7, ext_pol = 3'h0;
  logic [15:0] fault_delay [6], safety_delay [5], chk_delay = 16'h0002;
  logic [3:0] log_idx = 4'h0, log_count;
  pms_fault_type fault_raw = '0;
  pms_safety_type safety_raw = '0;
  pms_switch_type drive, sense;
  pms_mode_type mode;
  pms_log_entry_type log_data;
  logic fuse, meas_start, flash_store, safety_enable;
  int bad_count = 0, n_tests = 0, cyc = 0;
  initial for (int i = 0; i < 6; i++) fault_delay[i] = 16'h0001;
  initial for (int i = 0; i < 5; i++) safety_delay[i] = 16'h0004;
  initial forever #5 core_clk = ~core_clk;
  pms_power_safety #(.TICK_CYCLES(4), .ACTIVE_TICKS(2), .STANDBY_TICKS(4), .SHIP_TICKS(6),
    .IDLE_TICKS(10)) u_pms_power_safety (
    .core_clk(core_clk), .rst_n(rst_n), .fault_raw(fault_raw), .safety_raw(safety_raw),
    .fault_delay(fault_delay), .safety_delay(safety_delay), .switch_check_delay(chk_delay),
    .fault_clear(fault_clear), .load_active(load_active), .cell_below_deep_uv(below),
    .cell_above_recovery(above), .charger_present(charger), .ship_cmd(ship_cmd),
    .host_bus_activity(host_act), .ext_switch_in(ext_in), .ext_polarity(ext_pol),
    .switch_sense(sense), .log_rd_index(log_idx), .switch_drive(drive),
    .fuse_trip_output(fuse), .meas_start(meas_start), .flash_store(flash_store),
    .safety_enable(safety_enable), .mode(mode), .log_rd_data(log_data), .log_count(log_count));
  pms_switch_model u_pms_switch_model (.core_clk(core_clk), .rst_n(rst_n),
    .switch_drive(drive), .stuck_closed(stuck), .switch_sense(sense));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic pulse_ship();
    @(posedge core_clk) ship_cmd <= 1'b1;
    @(posedge core_clk) ship_cmd <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(mode, PMS_ACTIVE)
    `CHK(safety_enable, 1'b1)
    `CHK(log_count, 4'h0)
    `WT(meas_start)
    `CHK(meas_start, 1'b1)
    load_active <= 1'b0;
    `WT(mode == PMS_STANDBY)
    `CHK(mode, PMS_STANDBY)
    `CHK(safety_enable, 1'b1)
    load_active <= 1'b1;
    `WT(mode == PMS_ACTIVE)
    `CHK(mode, PMS_ACTIVE)
    pulse_ship();
    `WT(mode == PMS_SHIP)
    @(posedge core_clk);
    `CHK(mode, PMS_SHIP)
    `CHK(drive, 3'h0)
    `CHK(safety_enable, 1'b0)
    `WT(flash_store)
    `CHK(flash_store, 1'b1)
    host_act <= 1'b1;
    `WT(mode == PMS_ACTIVE)
    `CHK(mode, PMS_ACTIVE)
    host_act <= 1'b0;
    charger <= 1'b1;
    below <= 1'b1;
    `WT(mode == PMS_DEEP_UV)
    @(posedge core_clk);
    `CHK(mode, PMS_DEEP_UV)
    `CHK(drive, 3'h1)
    pulse_ship();
    repeat (6) @(posedge core_clk);
    `CHK(mode, PMS_DEEP_UV)
    below <= 1'b0;
    above <= 1'b1;
    `WT(mode == PMS_ACTIVE)
    `CHK(mode, PMS_ACTIVE)
    repeat (3) @(posedge core_clk);
    `CHK(drive.dsg, 1'b1)
    // over-voltage on a cell must open the switches and enter the log
    fault_raw.cell_ov <= 1'b1;
    `WT(drive == 3'h0)
    @(posedge core_clk);
    `CHK(drive, 3'h0)
    `CHK(log_count, 4'h1)
    `CHK(log_data.code, 6'h02)
    // the open stays latched after the fault goes, until a clear
    fault_raw.cell_ov <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(drive, 3'h0)
    fault_clear <= 1'b1;
    `WT(drive == 3'h7)
    `CHK(drive, 3'h7)
    fault_clear <= 1'b0;
    // bit 0 now equals its active level, so the switches must open
    ext_in <= 3'h6;
    `WT(drive == 3'h0)
    `CHK(drive, 3'h0)
    log_idx <= 4'ha;
    @(posedge core_clk);
    #1 `CHK(log_data, 22'h0)
    `CHK(fuse, 1'b0)
    stuck <= 1'b1;
    `WT(fuse)
    `CHK(fuse, 1'b1)
    repeat (4) @(posedge core_clk);
    `CHK(fuse, 1'b1)
    conclude();
  end
endmodule
